// ==== include/dpit_pkg.sv ====
/*
  Package for the dual programmable interval timer: register addresses,
  control field positions, vector field layout, reset values and the
  microsecond prescale count.
  Assumes a 32-bit register port with byte addresses and a 40 MHz clock.
*/
`default_nettype none

package dpit_pkg;

  // ************************************************************
  // register addresses (byte addresses, one word each)
  // ************************************************************
  localparam logic [31:0] DPIT_TIMER0_CONTROL_ADDR       = 32'h1014_0100;
  localparam logic [31:0] DPIT_TIMER0_INTERVAL_COUNT_ADDR = 32'h1014_0104;
  localparam logic [31:0] DPIT_TIMER0_NEXT_INTERVAL_ADDR = 32'h1014_0108;
  localparam logic [31:0] DPIT_TIMER0_VECTOR_ADDR        = 32'h1014_010C;
  localparam logic [31:0] DPIT_TIMER1_CONTROL_ADDR       = 32'h1014_0110;
  localparam logic [31:0] DPIT_TIMER1_INTERVAL_COUNT_ADDR = 32'h1014_0114;
  localparam logic [31:0] DPIT_TIMER1_NEXT_INTERVAL_ADDR = 32'h1014_0118;
  localparam logic [31:0] DPIT_TIMER1_VECTOR_ADDR        = 32'h1014_011C;

  // decode: base, block stride between timers and word offset within a timer
  localparam logic [31:0] DPIT_BASE_MASK   = 32'hFFFF_FFE0;
  localparam logic [31:0] DPIT_BASE_ADDR   = 32'h1014_0100;
  localparam int          DPIT_TIMER_SEL_BIT = 4;
  localparam logic [1:0]  DPIT_OFS_CONTROL = 2'h0;
  localparam logic [1:0]  DPIT_OFS_COUNT   = 2'h1;
  localparam logic [1:0]  DPIT_OFS_NEXT    = 2'h2;
  localparam logic [1:0]  DPIT_OFS_VECTOR  = 2'h3;

  // ************************************************************
  // control field positions
  // ************************************************************
  localparam int DPIT_CTL_MISSED_BIT  = 31;
  localparam int DPIT_CTL_WRAP_BIT    = 7;
  localparam int DPIT_CTL_ALLOW_BIT   = 6;
  localparam int DPIT_CTL_STEP_BIT    = 5;
  localparam int DPIT_CTL_LOAD_BIT    = 4;
  localparam int DPIT_CTL_HALT_BIT    = 2;
  localparam int DPIT_CTL_RUN_BIT     = 0;

  // vector field lies in bits 9..2
  localparam logic [31:0] DPIT_VECTOR_MASK = 32'h0000_03FC;

  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [31:0] DPIT_WORD_RESET = 32'h0000_0000;
  localparam int          DPIT_CLK_HZ     = 40_000_000;
  localparam int          DPIT_TICK_NS    = 1000;
  localparam int          DPIT_CLK_NS     = 1_000_000_000 / DPIT_CLK_HZ;
  localparam int          DPIT_TICK_CYCLES = DPIT_TICK_NS / DPIT_CLK_NS;
  localparam logic [7:0]  DPIT_TICK_LAST  = 8'(DPIT_TICK_CYCLES - 1);
  localparam int          DPIT_PRIORITY_LEVEL = 14;

endpackage

`default_nettype wire

// ==== design/dpit_timer.sv ====
/*
  One programmable interval timer: control flags, 32-bit interval counter,
  reload value and interrupt vector, with write-one-to-clear status.
  Assumes a one-cycle microsecond tick and a one-cycle write strobe from
  the parent; the parent decodes addresses and arbitrates the two timers.
*/
`default_nettype none

module dpit_timer
  import dpit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_ofs,
  input  wire logic [31:0] wr_data,
  input  wire logic        ack,
  output logic [31:0]      control_rd,
  output logic [31:0]      count_rd,
  output logic [31:0]      next_rd,
  output logic [31:0]      vector_rd,
  output logic             irq_req
);

  typedef struct packed {
    logic        missed;
    logic        wrapped;
    logic        irq_allow;
    logic        halt_on_wrap;
    logic        run;
    logic [31:0] count;
    logic [31:0] reload;
    logic [7:0]  vector;
  } dpit_tmr_type;

  dpit_tmr_type st_ff;
  dpit_tmr_type nxt_st;

  // ************************************************************
  // next-state logic
  // ************************************************************
  // one combinational pass: software effects first, then hardware events,
  // so that a wrap in the same cycle as a clear leaves the flag set
  always_comb
  begin
    logic        w_ctl;
    logic        step;
    logic        inc;
    logic        ovf;
    logic [32:0] sum;
    inc    = 1'b0;
    ovf    = 1'b0;
    sum    = 33'h0_0000_0000;
    nxt_st = st_ff;
    w_ctl  = wr_en && (wr_ofs == DPIT_OFS_CONTROL);
    step   = 1'b0;
    if (w_ctl)
    begin
      if (wr_data[DPIT_CTL_MISSED_BIT])
        nxt_st.missed = 1'b0;
      if (wr_data[DPIT_CTL_WRAP_BIT])
        nxt_st.wrapped = 1'b0;
      nxt_st.irq_allow    = wr_data[DPIT_CTL_ALLOW_BIT];
      nxt_st.halt_on_wrap = wr_data[DPIT_CTL_HALT_BIT];
      nxt_st.run          = wr_data[DPIT_CTL_RUN_BIT];
      step = wr_data[DPIT_CTL_STEP_BIT] && !st_ff.run;
    end
    if (wr_en && (wr_ofs == DPIT_OFS_COUNT) && wr_data[0] && !st_ff.run)
      step = 1'b1;
    if (wr_en && (wr_ofs == DPIT_OFS_NEXT))
      nxt_st.reload = wr_data;
    if (wr_en && (wr_ofs == DPIT_OFS_VECTOR))
      nxt_st.vector = wr_data[9:2];
    // acknowledge clears the wrap flag, then a new wrap may set it again
    if (ack)
      nxt_st.wrapped = 1'b0;
    inc = (st_ff.run && tick) || step;
    sum = {1'b0, st_ff.count} + 33'h0_0000_0001;
    ovf = inc && sum[32];
    if (w_ctl && wr_data[DPIT_CTL_LOAD_BIT])
      nxt_st.count = nxt_st.reload;
    else if (inc)
      nxt_st.count = sum[31:0];
    if (ovf)
    begin
      nxt_st.wrapped = 1'b1;
      if (st_ff.wrapped)
        nxt_st.missed = 1'b1;
      if (st_ff.run && st_ff.halt_on_wrap)
      begin
        nxt_st.run   = 1'b0;
        nxt_st.count = sum[31:0];
      end
      else
        nxt_st.count = st_ff.reload;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  // synchronous clear covers power-up and power-good loss while halted
  always_ff @(posedge clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // ************************************************************
  // read views and request
  // ************************************************************
  // unused bits and self-clearing command bits read zero
  always_comb
  begin
    control_rd = DPIT_WORD_RESET;
    control_rd[DPIT_CTL_MISSED_BIT] = st_ff.missed;
    control_rd[DPIT_CTL_WRAP_BIT]   = st_ff.wrapped;
    control_rd[DPIT_CTL_ALLOW_BIT]  = st_ff.irq_allow;
    control_rd[DPIT_CTL_HALT_BIT]   = st_ff.halt_on_wrap;
    control_rd[DPIT_CTL_RUN_BIT]    = st_ff.run;
  end

  assign count_rd  = st_ff.count;
  assign next_rd   = st_ff.reload;
  assign vector_rd = {22'h00_0000, st_ff.vector, 2'h0} & DPIT_VECTOR_MASK;
  assign irq_req   = st_ff.irq_allow && st_ff.wrapped;

endmodule

`default_nettype wire

// ==== design/dpit_top.sv ====
/*
  Dual programmable interval timer: two timers behind a word register port,
  a shared microsecond prescaler, and fixed-priority interrupt arbitration
  at the timers' level with the console serial unit ahead of both.
  Assumes a single-cycle register port on clk, power-good and halt levels
  from outside the clock domain, and an acknowledge pulse from logic on clk.
*/
`default_nettype none

// Function
// - overflow while wrap flag already set sets missed-overflow bit 31.
// - writing one clears missed bit or wrap flag; zero leaves them.
// - every counter overflow sets wrap flag bit 7.
// - wrap flag and allow bit 6 together post a level-14 request.
// - single-step bit 5 increments only when stopped; always reads zero.
// - load-now bit 4 copies reload into counter at once; reads zero.
// - halt-on-wrap bit 2 at overflow while running clears run, stops.
// - run bit 0 set increments counter every microsecond, else none.
// - otherwise overflow reloads counter from reload value and continues.
// - counter read-only; writing one while stopped increments it.
// - both timers' registers clear at power-up and power-good loss while halted.
// - control bits 30..8, 3 and 1 read zero; software writes zero.
// - reload register read/write; feeds counter on overflow or load-now.
// - vector bits 31..10 and 1..0 read zero; bits 9..2 hold vector.
// - acknowledge returns that timer's vector and clears its wrap flag.
// - clearing allow bit or wrap flag withdraws the request.
// - console serial beats both timers; timer 0 beats timer 1.
// - two independent timers, each with its own registers.
module dpit_top
  import dpit_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        dc_power_good,
  input  wire logic        cpu_halted,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic [31:0]      reg_rdata,
  output logic             reg_hit,
  input  wire logic        console_irq,
  input  wire logic        irq_ack,
  output logic             priority_level_req,
  output logic [1:0]       irq_grant,
  output logic [31:0]      ack_vector
);
  import dpit_pkg::*;

  localparam int NUM_TIMERS = 2;

  typedef struct packed {
    logic [1:0]  pg_sync;
    logic [1:0]  halt_sync;
    logic        pg_last;
    logic        soft_clear;
    logic [7:0]  presc;
    logic        tick;
    logic [31:0] rdata;
    logic        hit;
    logic [31:0] ack_vec;
  } dpit_top_type;

  dpit_top_type st_ff;
  dpit_top_type nxt_st;

  logic [31:0] ctl_rd [NUM_TIMERS];
  logic [31:0] cnt_rd [NUM_TIMERS];
  logic [31:0] nxt_rd [NUM_TIMERS];
  logic [31:0] vec_rd [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] req;
  logic [NUM_TIMERS-1:0] ack;
  logic [NUM_TIMERS-1:0] sel;
  logic        in_block;
  logic [1:0]  ofs;
  logic        timer_rst;

  // ************************************************************
  // address decode
  // ************************************************************
  // one 32-byte window, timer chosen by address bit 4
  assign in_block  = (reg_addr & DPIT_BASE_MASK) == DPIT_BASE_ADDR;
  assign ofs       = reg_addr[3:2];
  assign sel[0]    = in_block && !reg_addr[DPIT_TIMER_SEL_BIT];
  assign sel[1]    = in_block && reg_addr[DPIT_TIMER_SEL_BIT];
  assign timer_rst = rst || st_ff.soft_clear;

  // ************************************************************
  // interrupt arbitration
  // ************************************************************
  // console wins, then timer 0, then timer 1; grant is level until ack
  always_comb
  begin
    irq_grant = 2'h0;
    if (!console_irq)
    begin
      if (req[0])
        irq_grant = 2'h1;
      else if (req[1])
        irq_grant = 2'h2;
    end
  end

  assign ack                = irq_ack ? irq_grant : 2'h0;
  assign priority_level_req = |req;

  // ************************************************************
  // timers
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < NUM_TIMERS; g++)
    begin : g_timer
      dpit_timer u_timer
      (
        .clk        (clk),
        .rst        (timer_rst),
        .tick       (st_ff.tick),
        .wr_en      (reg_wr && sel[g]),
        .wr_ofs     (ofs),
        .wr_data    (reg_wdata),
        .ack        (ack[g]),
        .control_rd (ctl_rd[g]),
        .count_rd   (cnt_rd[g]),
        .next_rd    (nxt_rd[g]),
        .vector_rd  (vec_rd[g]),
        .irq_req    (req[g])
      );
    end
  endgenerate

  // ************************************************************
  // prescaler, power-good watch, read data
  // ************************************************************
  // pins pass two flops before the falling-edge detect reads them
  always_comb
  begin
    logic idx;
    logic [31:0] word;
    idx    = 1'b0;
    word   = DPIT_WORD_RESET;
    nxt_st = st_ff;
    nxt_st.pg_sync   = {st_ff.pg_sync[0], dc_power_good};
    nxt_st.halt_sync = {st_ff.halt_sync[0], cpu_halted};
    nxt_st.pg_last   = st_ff.pg_sync[1];
    nxt_st.soft_clear = st_ff.pg_last && !st_ff.pg_sync[1] && st_ff.halt_sync[1];
    // free-running tick, so timers keep a common microsecond phase
    if (st_ff.presc == DPIT_TICK_LAST)
    begin
      nxt_st.presc = 8'h00;
      nxt_st.tick  = 1'b1;
    end
    else
    begin
      nxt_st.presc = st_ff.presc + 8'h01;
      nxt_st.tick  = 1'b0;
    end
    idx  = reg_addr[DPIT_TIMER_SEL_BIT];
    case (ofs)
      DPIT_OFS_CONTROL: word = ctl_rd[idx];
      DPIT_OFS_COUNT:   word = cnt_rd[idx];
      DPIT_OFS_NEXT:    word = nxt_rd[idx];
      DPIT_OFS_VECTOR:  word = vec_rd[idx];
      default:          word = DPIT_WORD_RESET;
    endcase
    nxt_st.hit   = reg_rd && in_block;
    // unmapped reads return zero
    nxt_st.rdata = (reg_rd && in_block) ? word : DPIT_WORD_RESET;
    if (ack[0])
      nxt_st.ack_vec = vec_rd[0];
    else if (ack[1])
      nxt_st.ack_vec = vec_rd[1];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.pg_sync <= 2'h3;
      st_ff.pg_last <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  assign reg_rdata  = st_ff.rdata;
  assign reg_hit    = st_ff.hit;
  assign ack_vector = st_ff.ack_vec;

endmodule

`default_nettype wire

// ==== test/dpit_checker.sv ====
/*
  Checker for dpit_top: register port and interrupt grant relations.
  Assumes it is bound onto dpit_top; one clock, synchronous reset.
*/
`default_nettype none

module dpit_checker
  import dpit_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_hit,
  input wire logic        console_irq,
  input wire logic        irq_ack,
  input wire logic        priority_level_req,
  input wire logic [1:0]  irq_grant,
  input wire logic [31:0] ack_vector
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ************************************************************
  // read and acknowledge relations
  // ************************************************************
  sequence rd_in;
    reg_rd && ((reg_addr & DPIT_BASE_MASK) == DPIT_BASE_ADDR);
  endsequence
  sequence ack_taken;
    irq_ack && (irq_grant != 2'h0);
  endsequence

  idle_rdata_a: assert property (!reg_rd |=> reg_rdata == 32'h0 && !reg_hit)
    else $error("read data without a read");
  window_hit_a: assert property (rd_in |=> reg_hit)
    else $error("mapped read not answered");
  outside_miss_a: assert property (reg_rd && reg_addr[31:5] != DPIT_BASE_ADDR[31:5]
    |=> !reg_hit && reg_rdata == 32'h0) else $error("unmapped read answered");
  ctl_reserved_a: assert property (rd_in ##0 reg_addr[3:0] == 4'h0 |=>
    (reg_rdata & 32'h7FFF_FF3A) == 32'h0) else $error("control reserved bits set");
  vec_reserved_a: assert property (rd_in ##0 reg_addr[3:0] == 4'hC |=>
    (reg_rdata & ~DPIT_VECTOR_MASK) == 32'h0) else $error("vector reserved bits set");
  console_first_a: assert property (console_irq |-> irq_grant == 2'h0)
    else $error("timer granted over console");
  grant_req_a: assert property (irq_grant != 2'h0 |->
    priority_level_req && $onehot(irq_grant)) else $error("grant without request");
  req_grant_a: assert property (priority_level_req && !console_irq |->
    irq_grant != 2'h0) else $error("request left ungranted");
  idle_ack_a: assert property (irq_ack && irq_grant == 2'h0 |=>
    $stable(ack_vector)) else $error("vector changed without grant");
  ack_field_a: assert property (ack_taken |=>
    (ack_vector & ~DPIT_VECTOR_MASK) == 32'h0) else $error("vector field leaked");
endmodule

bind dpit_top dpit_checker chk (.clk(clk), .rst(rst), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .console_irq(console_irq), .irq_ack(irq_ack),
  .priority_level_req(priority_level_req), .irq_grant(irq_grant),
  .ack_vector(ack_vector));

`default_nettype wire

// ==== test/dpit_host.sv ====
/*
  Host model: processor register strobes and interrupt acknowledge.
  Assumes callers wait for reset release; each access takes two edges.
*/
`default_nettype none

module dpit_host
(
  input  wire logic        clk,
  input  wire logic [31:0] reg_rdata,
  input  wire logic        reg_hit,
  input  wire logic [31:0] ack_vector,
  output var logic         reg_wr,
  output var logic         reg_rd,
  output var logic [31:0]  reg_addr,
  output var logic [31:0]  reg_wdata,
  output var logic         irq_ack
);
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // bus cycles, launched 1 ns after an edge
  // ************************************************************
  initial
  begin
    {reg_wr, reg_rd, irq_ack} = 3'h0;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
  end

  // callers keep reserved bits zero
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    #1;
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~d; // stale data must not matter
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic h);
    @(posedge clk);
    #1;
    {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d = reg_rdata;
    h = reg_hit;
  endtask

  task automatic ack(output logic [31:0] v);
    @(posedge clk);
    #1;
    irq_ack = 1'b1;
    @(posedge clk);
    #1;
    irq_ack = 1'b0;
    v = ack_vector;
  endtask
endmodule

`default_nettype wire

// ==== test/dpit_top_test.sv ====
/*
  Self-checking bench for dpit_top: register, overflow and interrupt runs.
  Assumes dpit_host drives the register port and acknowledge.
*/
`default_nettype none

module dpit_top_test;
  timeunit 1ns;
  // half period of 12.5 ns needs sub-nanosecond precision to keep 25 ns
  timeprecision 100ps;
  import dpit_pkg::*;

  // ************************************************************
  // signals, clock, design and host
  // ************************************************************
  localparam logic [31:0] B = DPIT_BASE_ADDR;
  logic        clk, rst, pg, halted, con, wr, rd, ack, hit, req;
  logic [31:0] addr, wdata, rdata, avec, v;
  logic [1:0]  grant;
  int          miscompares, checked;

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  dpit_top DUT (.clk(clk), .rst(rst), .dc_power_good(pg), .cpu_halted(halted),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_hit(hit), .console_irq(con), .irq_ack(ack), .priority_level_req(req),
    .irq_grant(grant), .ack_vector(avec));
  dpit_host host (.clk(clk), .reg_rdata(rdata), .reg_hit(hit), .ack_vector(avec),
    .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata), .irq_ack(ack));

  // ************************************************************
  // compare, wait and closing helpers
  // ************************************************************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // mapped addresses must also raise the hit flag
  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        h;
    host.rd(a, d, h);
    chk(d, e);
    chk({31'h0, h}, {31'h0, a[31:5] == B[31:5]});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // bounded wait for an overflow request
  task automatic wait_req;
    int n;
    n = 0;
    while (req !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n == 200)
    begin
      miscompares++;
      tally_and_finish();
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    {miscompares, checked} = 0;
    {rst, pg, halted, con} = 4'hC;
    cyc(16);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      rc(B + 32'(4 * i), 32'h0);
    rc(B + 32'h20, 32'h0);
    host.wr(B + 32'h8, 32'hFFFF_FFFF);
    host.wr(B + 32'h18, 32'hFFFF_FFFE);
    host.wr(B + 32'hC, 32'h3FC);
    host.wr(B + 32'h1C, 32'h204);
    rc(B + 32'h8, 32'hFFFF_FFFF);
    rc(B + 32'h18, 32'hFFFF_FFFE);
    rc(B + 32'h1C, 32'h204);
    host.wr(B, 32'h20);
    host.wr(B + 32'h4, 32'h1);
    rc(B + 32'h4, 32'h2);
    rc(B, 32'h0);
    // timer 0 loads all ones, runs and halts on its wrap
    host.wr(B, 32'h55);
    wait_req();
    chk({30'h0, grant}, 32'h1);
    cyc(50);
    rc(B, 32'hC4);
    rc(B + 32'h4, 32'h0);
    con = 1'b1;
    cyc(1);
    chk({30'h0, grant}, 32'h0);
    con = 1'b0;
    host.ack(v);
    chk(v, 32'h3FC);
    chk({31'h0, req}, 32'h0);
    // timer 1 wraps twice while running, no halt
    host.wr(B + 32'h10, 32'h51);
    wait_req();
    chk({30'h0, grant}, 32'h2);
    cyc(90);
    host.wr(B + 32'h10, 32'h40);
    rc(B + 32'h10, 32'h8000_00C0);
    rc(B + 32'h14, 32'hFFFF_FFFE);
    host.wr(B + 32'h10, 32'h0);
    chk({31'h0, req}, 32'h0);
    rc(B + 32'h10, 32'h8000_0080);
    host.wr(B + 32'h10, 32'h8000_0080);
    rc(B + 32'h10, 32'h0);
    // both timers pending through single steps across the wrap
    host.wr(B, 32'h50);
    host.wr(B, 32'h60);
    host.wr(B + 32'h10, 32'h50);
    host.wr(B + 32'h10, 32'h60);
    host.wr(B + 32'h10, 32'h60);
    chk({30'h0, grant}, 32'h1);
    rc(B + 32'h4, 32'hFFFF_FFFF);
    host.ack(v);
    chk(v, 32'h3FC);
    chk({30'h0, grant}, 32'h2);
    host.ack(v);
    chk(v, 32'h204);
    chk({31'h0, req}, 32'h0);
    // acknowledge with nothing granted leaves the last vector in place
    host.ack(v);
    chk(v, 32'h204);
    // power loss while halted wipes both timers
    halted = 1'b1;
    pg = 1'b0;
    cyc(10);
    rc(B + 32'hC, 32'h0);
    rc(B + 32'h18, 32'h0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
